// File: logic/mswc_monitor.sv
// Monitor-mode single-wire command port: entry, security, echo, commands
//
// Overview of operation
// - Wait for eight security bytes first
// - Send ten-low break when ready
// - Compare bytes against FFF6..FFFD in order
// - Monitor mode uses FE-page vectors
// - Watchdog off while high voltage present
// - Bus clock from crystal under IRQ voltage
// - Otherwise clock select bit chooses source
// - Same NRZ baud for both directions
// - Echo every byte except non-break bytes taken in the pause, result after echo
// - On break drive high two bits, echo
// - Eleven-bit pause, break cancels command
// - Two-bit gap before every sent byte
// - Indexed read returns next two bytes
// - Indexed write stores at last plus one
// - Stack query returns SP+1 high first
// - Run pulls index high, returns interrupt
// - Entry stacks frame, SP ends 00F9
// - Frame layout SP+1 to SP+6
// - Baud is crystal divided by 1024
// - Passed security holds until power-on
// - Failed security hides nonvolatile memory
`timescale 1ns/1ps
module mswc_monitor import mswc_pkg::*; #(
  parameter int BIT_CYCLES = BIT_CYCLES_DFLT,
  parameter logic [15:0] NV_BASE = NV_BASE_DFLT
) (
  input logic sys_clk_i,
  input logic rst_n_i,
  input logic cpu_reset_i,
  input logic serial_in_i,
  output logic serial_out_o,
  output logic serial_oe_o,
  input logic irq_test_voltage_i,
  input logic irq_high_voltage_i,
  input logic rst_high_voltage_i,
  input logic entry_sel_a_i,
  input logic entry_sel_b_i,
  input logic clk_sel_bit_i,
  input logic swi_entry_i,
  input logic [15:0] sp_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input logic [7:0] mem_rdata_i,
  input logic mem_ack_i,
  output logic monitor_mode_o,
  output logic security_bypass_o,
  output logic nv_lock_o,
  output logic watchdog_disable_o,
  output logic bus_clk_xtal_o,
  output logic [15:0] reset_vector_o,
  output logic [15:0] swi_vector_o,
  output logic stack_entry_o,
  output logic resume_o
);

  localparam int DW = $clog2(BIT_CYCLES + 1);
  localparam logic [DW-1:0] BIT_LAST = DW'(BIT_CYCLES - 1);
  localparam logic [DW-1:0] BIT_HALF = DW'(BIT_CYCLES / 2);

  // Argument bytes that follow each opcode
  function automatic logic [1:0] op_args(input logic [7:0] op);
    case (op)
      CMD_READ: op_args = 2'h2;
      CMD_WRITE: op_args = 2'h3;
      CMD_INDEXED_WRITE_CMD: op_args = 2'h1;
      default: op_args = 2'h0;
    endcase
  endfunction : op_args

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic ser_s;
  logic irq_tst_s;
  logic irq_hv_s;
  logic rst_hv_s;
  logic sel_a_s;
  logic sel_b_s;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= 6'h3F;
      sync2_r <= 6'h3F;
    end else begin
      sync1_r <= {serial_in_i, irq_test_voltage_i, irq_high_voltage_i,
                  rst_high_voltage_i, entry_sel_a_i, entry_sel_b_i};
      sync2_r <= sync1_r;
    end
  end

  assign {ser_s, irq_tst_s, irq_hv_s, rst_hv_s, sel_a_s, sel_b_s} = sync2_r;

  ////////////////////////////////////////////////////////////////////////////
  // Entry capture after reset release
  logic [1:0] settle_r;
  logic pend_r;
  logic mon_r;
  logic stk_r;
  logic entry_ok;

  assign entry_ok = irq_tst_s & sel_a_s & ~sel_b_s & ser_s;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_r <= 2'h0;
      pend_r <= 1'b1;
      mon_r <= 1'b0;
      stk_r <= 1'b0;
    end else begin
      stk_r <= 1'b0;
      if (cpu_reset_i) begin
        pend_r <= 1'b1;
        settle_r <= 2'h0;
      end else if (settle_r != SETTLE_MAX) begin
        settle_r <= settle_r + 2'h1;
      end else if (pend_r) begin
        pend_r <= 1'b0;
        mon_r <= entry_ok;
        stk_r <= entry_ok;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free-running bit-time divider, crystal-derived rate
  logic [DW-1:0] div_r;
  logic bit_tick;

  assign bit_tick = (div_r == BIT_LAST);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= '0;
    end else begin
      div_r <= bit_tick ? '0 : div_r + DW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: two-bit high gap then frame or break
  logic [1:0] tx_gap_r;
  logic [3:0] tx_left_r;
  logic [9:0] tx_sh_r;
  logic tx_go_r;
  logic tx_brk_r;
  logic [7:0] tx_byte_r;
  logic tx_busy;
  logic out_r;
  logic oe_r;

  assign tx_busy = (tx_gap_r != 2'h0) | (tx_left_r != 4'h0);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_gap_r <= 2'h0;
      tx_left_r <= 4'h0;
      tx_sh_r <= 10'h3FF;
    end else if (tx_go_r) begin
      tx_gap_r <= GAP_BITS;
      tx_left_r <= tx_brk_r ? BREAK_BITS : FRAME_BITS;
      tx_sh_r <= tx_brk_r ? 10'h000 : {1'b1, tx_byte_r, 1'b0};
    end else if (bit_tick) begin
      if (tx_gap_r != 2'h0) begin
        tx_gap_r <= tx_gap_r - 2'h1;
      end else if (tx_left_r != 4'h0) begin
        tx_left_r <= tx_left_r - 4'h1;
        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
      end
    end
  end

  // Registered pin drive, high during gap
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      out_r <= (tx_gap_r != 2'h0) | tx_sh_r[0];
      oe_r <= tx_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver, idle while transmitting so own echo is ignored
  mswc_rx_e rx_st_r;
  logic [DW-1:0] rx_cnt_r;
  logic [3:0] rx_n_r;
  logic [8:0] rx_sh_r;
  logic rx_vld_r;
  logic [8:0] rx_word_r;
  logic rx_rdy;
  logic rx_is_brk;
  logic rx_ok;

  assign rx_is_brk = ~ser_s & (rx_sh_r[8:1] == 8'h00);
  assign rx_ok = ser_s | rx_is_brk;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st_r <= RX_IDLE;
      rx_cnt_r <= '0;
      rx_n_r <= 4'h0;
      rx_sh_r <= 9'h000;
      rx_vld_r <= 1'b0;
      rx_word_r <= 9'h000;
    end else begin
      case (rx_st_r)
        RX_IDLE: begin
          rx_cnt_r <= '0;
          if (!ser_s && !tx_busy && !tx_go_r) begin
            rx_st_r <= RX_HALF;
          end
        end
        RX_HALF: begin
          rx_cnt_r <= rx_cnt_r + DW'(1);
          if (rx_cnt_r == BIT_HALF) begin
            rx_cnt_r <= '0;
            rx_n_r <= 4'h0;
            rx_st_r <= ser_s ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          rx_cnt_r <= rx_cnt_r + DW'(1);
          if (rx_cnt_r == BIT_LAST) begin
            rx_cnt_r <= '0;
            rx_sh_r <= {ser_s, rx_sh_r[8:1]};
            rx_n_r <= rx_n_r + 4'h1;
            if (rx_n_r == RX_SAMPLES - 4'h1) begin
              rx_vld_r <= rx_ok;
              rx_word_r <= {rx_is_brk, rx_sh_r[8:1]};
              rx_st_r <= RX_HOLD;
            end
          end
        end
        RX_HOLD: begin
          if (rx_vld_r && rx_rdy) begin
            rx_vld_r <= 1'b0;
          end
          if ((!rx_vld_r || rx_rdy) && ser_s) begin
            rx_st_r <= RX_IDLE;
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte buffer toward the command engine
  logic b_vld;
  logic b_rdy;
  logic [8:0] b_word;
  logic take;
  logic b_brk;
  logic [7:0] b_data;

  mswc_buf2 #(.W(9)) u_buf (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rx_vld_r),
    .in_ready_o(rx_rdy),
    .in_data_i(rx_word_r),
    .out_valid_o(b_vld),
    .out_ready_i(b_rdy),
    .out_data_o(b_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command engine
  mswc_cmd_e st_r;
  mswc_cmd_e ret_r;
  logic [2:0] idx_r;
  logic match_r;
  logic sec_done_r;
  logic sec_pass_r;
  logic [7:0] opc_r;
  logic [23:0] arg_r;
  logic [1:0] left_r;
  logic [15:0] addr_r;
  logic [15:0] rep_r;
  logic [1:0] rep_n_r;
  logic [3:0] pause_r;
  logic mem_req_r;
  logic mem_we_r;
  logic [15:0] mem_addr_r;
  logic [7:0] mem_wdata_r;
  logic resume_r;
  logic nv_lock;
  logic [7:0] rd_byte;

  assign b_rdy = mon_r & ((st_r == CS_SEC_RX) | (st_r == CS_OP_RX) |
                          (st_r == CS_ARG_RX) | (st_r == CS_PAUSE));
  assign take = b_vld & b_rdy;
  assign b_brk = b_word[8];
  assign b_data = b_word[7:0];
  assign nv_lock = sec_done_r & ~sec_pass_r;
  assign rd_byte = (nv_lock && mem_addr_r >= NV_BASE) ? UNDEF_BYTE : mem_rdata_i;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= CS_SEC_RX;
      ret_r <= CS_OP_RX;
      idx_r <= 3'h0;
      match_r <= 1'b1;
      sec_done_r <= 1'b0;
      sec_pass_r <= 1'b0;
      opc_r <= 8'h00;
      arg_r <= 24'h000000;
      left_r <= 2'h0;
      addr_r <= 16'h0000;
      rep_r <= 16'h0000;
      rep_n_r <= 2'h0;
      pause_r <= 4'h0;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 16'h0000;
      mem_wdata_r <= 8'h00;
      tx_go_r <= 1'b0;
      tx_brk_r <= 1'b0;
      tx_byte_r <= 8'h00;
      resume_r <= 1'b0;
    end else begin
      tx_go_r <= 1'b0;
      resume_r <= 1'b0;
      if (cpu_reset_i || !mon_r) begin
        st_r <= CS_SEC_RX;
        idx_r <= 3'h0;
        match_r <= 1'b1;
        sec_done_r <= 1'b0;
        mem_req_r <= 1'b0;
        mem_we_r <= 1'b0;
      end else if (swi_entry_i && sec_done_r) begin
        st_r <= CS_BRK;
      end else begin
        case (st_r)
          CS_SEC_RX: if (take) begin
            arg_r[7:0] <= b_data;
            mem_addr_r <= SEC_BASE + {13'h0000, idx_r};
            mem_we_r <= 1'b0;
            mem_req_r <= 1'b1;
            st_r <= CS_SEC_RD;
          end
          CS_SEC_RD: if (mem_ack_i) begin
            mem_req_r <= 1'b0;
            match_r <= match_r & (mem_rdata_i == arg_r[7:0]);
            tx_go_r <= 1'b1;
            tx_brk_r <= 1'b0;
            tx_byte_r <= arg_r[7:0];
            idx_r <= idx_r + 3'h1;
            ret_r <= (idx_r == SEC_LAST) ? CS_SEC_BRK : CS_SEC_RX;
            st_r <= CS_TXW;
          end
          CS_SEC_BRK: begin
            sec_done_r <= 1'b1;
            sec_pass_r <= sec_pass_r | match_r;
            tx_go_r <= 1'b1;
            tx_brk_r <= 1'b1;
            ret_r <= CS_OP_RX;
            st_r <= CS_TXW;
          end
          CS_TXW: if (!tx_busy && !tx_go_r) begin
            st_r <= ret_r;
          end
          CS_OP_RX: if (take) begin
            if (b_brk) begin
              st_r <= CS_BRK;
            end else begin
              opc_r <= b_data;
              left_r <= op_args(b_data);
              tx_go_r <= 1'b1;
              tx_brk_r <= 1'b0;
              tx_byte_r <= b_data;
              ret_r <= (op_args(b_data) != 2'h0) ? CS_ARG_RX : CS_DO;
              st_r <= CS_TXW;
            end
          end
          CS_ARG_RX: if (take) begin
            if (b_brk) begin
              st_r <= CS_BRK;
            end else begin
              arg_r <= {arg_r[15:0], b_data};
              left_r <= left_r - 2'h1;
              tx_go_r <= 1'b1;
              tx_brk_r <= 1'b0;
              tx_byte_r <= b_data;
              ret_r <= (left_r == 2'h1) ? CS_DO : CS_ARG_RX;
              st_r <= CS_TXW;
            end
          end
          CS_DO: begin
            pause_r <= 4'h0;
            case (opc_r)
              CMD_READ: begin
                mem_addr_r <= arg_r[15:0];
                left_r <= 2'h1;
                st_r <= CS_MEM;
              end
              CMD_INDEXED_READ_CMD: begin
                mem_addr_r <= addr_r + 16'h0001;
                left_r <= 2'h2;
                st_r <= CS_MEM;
              end
              CMD_STACK_POINTER_QUERY_CMD: begin
                rep_r <= sp_i + STK_OFS_H;
                rep_n_r <= 2'h2;
                st_r <= CS_REPLY;
              end
              default: st_r <= CS_PAUSE;
            endcase
          end
          CS_MEM: begin
            mem_we_r <= 1'b0;
            if (!mem_req_r) begin
              mem_req_r <= 1'b1;
            end else if (mem_ack_i) begin
              mem_req_r <= 1'b0;
              rep_r <= {rep_r[7:0], rd_byte};
              addr_r <= mem_addr_r;
              left_r <= left_r - 2'h1;
              mem_addr_r <= mem_addr_r + 16'h0001;
              if (left_r == 2'h1) begin
                rep_n_r <= (opc_r == CMD_INDEXED_READ_CMD) ? 2'h2 : 2'h1;
                st_r <= CS_REPLY;
              end
            end
          end
          CS_REPLY: begin
            tx_go_r <= 1'b1;
            tx_brk_r <= 1'b0;
            tx_byte_r <= (rep_n_r == 2'h2) ? rep_r[15:8] : rep_r[7:0];
            rep_n_r <= rep_n_r - 2'h1;
            ret_r <= (rep_n_r == 2'h1) ? CS_PAUSE : CS_REPLY;
            pause_r <= 4'h0;
            st_r <= CS_TXW;
          end
          CS_PAUSE: begin
            if (take && b_brk) begin
              st_r <= CS_BRK;
            end else if (pause_r != CMD_PAUSE_BITS) begin
              pause_r <= pause_r + 4'(bit_tick);
            end else if (rx_st_r == RX_IDLE && !b_vld) begin
              st_r <= CS_EXEC; // frame in flight may be a break
            end
          end
          CS_EXEC: begin
            mem_we_r <= 1'b1;
            mem_wdata_r <= arg_r[7:0];
            case (opc_r)
              CMD_WRITE: begin
                mem_addr_r <= arg_r[23:8];
                addr_r <= arg_r[23:8];
                st_r <= CS_WR;
              end
              CMD_INDEXED_WRITE_CMD: begin
                mem_addr_r <= addr_r + 16'h0001;
                addr_r <= addr_r + 16'h0001;
                st_r <= CS_WR;
              end
              CMD_RUN: begin
                mem_we_r <= 1'b0;
                resume_r <= 1'b1;
                st_r <= CS_OP_RX;
              end
              default: begin
                mem_we_r <= 1'b0;
                st_r <= CS_OP_RX;
              end
            endcase
          end
          CS_WR: begin
            if (!mem_req_r) begin
              mem_req_r <= 1'b1;
            end else if (mem_ack_i) begin
              mem_req_r <= 1'b0;
              mem_we_r <= 1'b0;
              st_r <= CS_OP_RX;
            end
          end
          CS_BRK: begin
            tx_go_r <= 1'b1;
            tx_brk_r <= 1'b1;
            ret_r <= CS_OP_RX;
            st_r <= CS_TXW;
          end
          default: st_r <= CS_SEC_RX;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered mode outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      monitor_mode_o <= 1'b0;
      security_bypass_o <= 1'b0;
      nv_lock_o <= 1'b0;
      watchdog_disable_o <= 1'b0;
      bus_clk_xtal_o <= 1'b0;
      reset_vector_o <= VEC_RESET_USR;
      swi_vector_o <= VEC_SWI_USR;
      stack_entry_o <= 1'b0;
      resume_o <= 1'b0;
    end else begin
      monitor_mode_o <= mon_r;
      security_bypass_o <= sec_pass_r;
      nv_lock_o <= nv_lock;
      watchdog_disable_o <= mon_r & (irq_hv_s | rst_hv_s);
      bus_clk_xtal_o <= (mon_r & irq_hv_s) | clk_sel_bit_i;
      reset_vector_o <= mon_r ? VEC_RESET_MON : VEC_RESET_USR;
      swi_vector_o <= mon_r ? VEC_SWI_MON : VEC_SWI_USR;
      stack_entry_o <= stk_r;
      resume_o <= resume_r;
    end
  end

  // Straight flop outputs
  assign serial_out_o = out_r;
  assign serial_oe_o = oe_r;
  assign mem_req_o = mem_req_r;
  assign mem_we_o = mem_we_r;
  assign mem_addr_o = mem_addr_r;
  assign mem_wdata_o = mem_wdata_r;

endmodule : mswc_monitor

// File: logic/mswc_pkg.sv
// Shared constants and state types for the monitor serial command port
package mswc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: system clock, crystal and derived bit time
  localparam int CLK_HZ = 125_000_000;
  localparam int XTAL_HZ_DFLT = 9_830_400;
  localparam int XTAL_PER_BAUD = 1024;
  localparam int BAUD_DFLT = XTAL_HZ_DFLT / XTAL_PER_BAUD;
  localparam int BIT_CYCLES_DFLT = CLK_HZ / BAUD_DFLT;

  // Bit-time counts on the serial pin, and the entry settle count in clock cycles
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] BREAK_BITS = 4'hA;
  localparam logic [3:0] RX_SAMPLES = 4'h9;
  localparam logic [1:0] GAP_BITS = 2'h2;
  localparam logic [3:0] CMD_PAUSE_BITS = 4'hB;
  localparam logic [1:0] SETTLE_MAX = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Security
  localparam logic [15:0] SEC_BASE = 16'hFFF6;
  localparam logic [2:0] SEC_LAST = 3'h7;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [7:0] UNDEF_BYTE = 8'h00;
  localparam logic [15:0] NV_BASE_DFLT = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // Command opcodes
  localparam logic [7:0] CMD_READ = 8'h4A;
  localparam logic [7:0] CMD_WRITE = 8'h49;
  localparam logic [7:0] CMD_INDEXED_READ_CMD = 8'h1A;
  localparam logic [7:0] CMD_INDEXED_WRITE_CMD = 8'h19;
  localparam logic [7:0] CMD_STACK_POINTER_QUERY_CMD = 8'h0C;
  localparam logic [7:0] CMD_RUN = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // Vectors and stack frame
  localparam logic [15:0] VEC_RESET_USR = 16'hFFFE;
  localparam logic [15:0] VEC_SWI_USR = 16'hFFFC;
  localparam logic [15:0] VEC_RESET_MON = 16'hFEFE;
  localparam logic [15:0] VEC_SWI_MON = 16'hFEFC;
  localparam logic [15:0] SP_AT_ENTRY = 16'h00F9;
  localparam logic [15:0] STK_OFS_H = 16'h0001;
  localparam logic [15:0] STK_OFS_CCR = 16'h0002;
  localparam logic [15:0] STK_OFS_A = 16'h0003;
  localparam logic [15:0] STK_OFS_X = 16'h0004;
  localparam logic [15:0] STK_OFS_PCH = 16'h0005;
  localparam logic [15:0] STK_OFS_PCL = 16'h0006;

  ////////////////////////////////////////////////////////////////////////////
  // State types
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_HALF = 4'b0010,
    RX_BITS = 4'b0100,
    RX_HOLD = 4'b1000
  } mswc_rx_e;

  typedef enum logic [12:0] {
    CS_SEC_RX = 13'b0000000000001,
    CS_SEC_RD = 13'b0000000000010,
    CS_SEC_BRK = 13'b0000000000100,
    CS_TXW = 13'b0000000001000,
    CS_OP_RX = 13'b0000000010000,
    CS_ARG_RX = 13'b0000000100000,
    CS_DO = 13'b0000001000000,
    CS_MEM = 13'b0000010000000,
    CS_REPLY = 13'b0000100000000,
    CS_PAUSE = 13'b0001000000000,
    CS_EXEC = 13'b0010000000000,
    CS_WR = 13'b0100000000000,
    CS_BRK = 13'b1000000000000
  } mswc_cmd_e;

endpackage : mswc_pkg

// File: logic/mswc_buf2.sv
// Two-entry valid/ready buffer between byte receiver and command engine
`timescale 1ns/1ps
module mswc_buf2 #(
  parameter int W = 9
) (
  input logic sys_clk_i,
  input logic rst_n_i,
  input logic in_valid_i,
  output logic in_ready_o,
  input logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  logic [W-1:0] slot_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = slot_r[rp_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  ////////////////////////////////////////////////////////////////////////////
  // Pointers and occupancy
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else begin
      if (push) begin
        slot_r[wp_r] <= in_data_i;
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end

endmodule : mswc_buf2

// File: tb/mswc_chk.sv
// Assertion checker for the monitor serial command port
`timescale 1ns/1ps
module mswc_chk import mswc_pkg::*; #(
  parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
  input logic sys_clk_i,
  input logic rst_n_i,
  input logic clk_sel_bit_i,
  input logic irq_high_voltage_i,
  input logic mem_ack_i,
  input logic serial_out_o,
  input logic serial_oe_o,
  input logic mem_req_o,
  input logic [15:0] mem_addr_o,
  input logic monitor_mode_o,
  input logic security_bypass_o,
  input logic nv_lock_o,
  input logic watchdog_disable_o,
  input logic bus_clk_xtal_o,
  input logic [15:0] reset_vector_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs
  property p_vec; monitor_mode_o [*3] |-> reset_vector_o == VEC_RESET_MON; endproperty
  a_vec: assert property (p_vec)
    else $error("wrong reset vector");
  property p_wd; (monitor_mode_o && irq_high_voltage_i) [*8] |-> watchdog_disable_o; endproperty
  a_wd: assert property (p_wd)
    else $error("watchdog not disabled");
  property p_xt; (monitor_mode_o && irq_high_voltage_i) [*8] |-> bus_clk_xtal_o; endproperty
  a_xt: assert property (p_xt)
    else $error("bus clock not from crystal");
  property p_cs; (!irq_high_voltage_i && !clk_sel_bit_i) [*8] |-> !bus_clk_xtal_o; endproperty
  a_cs: assert property (p_cs)
    else $error("clock select ignored");
  property p_byp; security_bypass_o |=> security_bypass_o; endproperty
  a_byp: assert property (p_byp)
    else $error("bypass lost");
  property p_lock; nv_lock_o |-> !security_bypass_o; endproperty
  a_lock: assert property (p_lock)
    else $error("lock with bypass");
  ////////////////////////////////////////////////////////////////////////////
  // Pin and memory
  property p_quiet; !monitor_mode_o |-> !serial_oe_o; endproperty
  a_quiet: assert property (p_quiet)
    else $error("pin driven");
  property p_gap; $rose(serial_oe_o) |-> serial_out_o [*8]; endproperty
  a_gap: assert property (p_gap)
    else $error("no gap");
  property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o); endproperty
  a_hold: assert property (p_hold)
    else $error("request not held");
  property p_drop; mem_req_o && mem_ack_i |=> !mem_req_o; endproperty
  a_drop: assert property (p_drop)
    else $error("request not dropped");
endmodule : mswc_chk
bind mswc_monitor mswc_chk #(.BIT_CYCLES(BIT_CYCLES)) chk_u (.*);

// File: tb/mswc_host.sv
// Host computer model on the wired-OR serial pin
`timescale 1ns/1ps
module mswc_host #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic sys_clk_i,
  input wire logic line_i,
  output logic tx_o
);
  initial tx_o = 1'b1;
  // Frame or ten-low break, LSB first
  task automatic send(input logic [7:0] b, input logic brk);
    logic [9:0] f;
    f = brk ? 10'h000 : {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx_o = f[i];
      repeat (BIT_CYCLES) @(posedge sys_clk_i);
      #1;
    end
    tx_o = 1'b1;
  endtask : send
  // Mid-bit samples, stop in bit 8
  task automatic recv(output logic [8:0] r);
    int n;
    n = 0;
    while (line_i !== 1'b0 && n < 40 * BIT_CYCLES) begin
      @(posedge sys_clk_i);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(posedge sys_clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYCLES) @(posedge sys_clk_i);
      r[i] = line_i;
    end
    #1;
  endtask : recv
endmodule : mswc_host

// File: tb/mswc_monitor_tb_top.sv
// Self-checking testbench for the monitor serial command port
`timescale 1ns/1ps
module mswc_monitor_tb_top import mswc_pkg::*; ();
  localparam int BIT = 16;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, cpu_reset_i = 1'b0, irq_test_voltage_i = 1'b1;
  logic irq_high_voltage_i = 1'b1, rst_high_voltage_i = 1'b0, entry_sel_a_i = 1'b1;
  logic entry_sel_b_i = 1'b0, clk_sel_bit_i = 1'b0, swi_entry_i = 1'b0, mem_ack_i = 1'b0;
  logic serial_out_o, serial_oe_o, host_tx, mem_req_o, mem_we_o, monitor_mode_o, nv_lock_o;
  logic security_bypass_o, watchdog_disable_o, bus_clk_xtal_o, stack_entry_o, resume_o;
  logic [15:0] sp_i = 16'h0000, mem_addr_o, reset_vector_o, swi_vector_o, a;
  logic [7:0] mem_rdata_i = 8'h00, mem_wdata_o, d, o;
  logic [7:0] mem [65536];
  logic [31:0] rnd = 32'h1D04;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  wire serial_in_i = (serial_oe_o ? serial_out_o : 1'b1) & host_tx; // Pull-up, low wins
  always #4 sys_clk_i = ~sys_clk_i;
  mswc_monitor #(.BIT_CYCLES(BIT)) dut_u (.*);
  mswc_host #(.BIT_CYCLES(BIT)) host_u (.sys_clk_i, .line_i(serial_in_i), .tx_o(host_tx));
  ////////////////////////////////////////////////////////////////////////////
  // Memory and cycle ceiling
  always @(posedge sys_clk_i) begin
    #1;
    mem_ack_i = mem_req_o & ~mem_ack_i;
    if (mem_ack_i) begin
      mem_rdata_i = mem[mem_addr_o];
      if (mem_we_o) mem[mem_addr_o] = mem_wdata_o;
    end
    if (++cyc == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  // Expected echo frame
  function automatic logic [8:0] fr(input logic [7:0] b, input logic brk);
    return brk ? 9'h000 : {1'b1, b};
  endfunction : fr
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wt
  task automatic rx(input logic [8:0] e);
    logic [8:0] r;
    host_u.recv(r);
    chk("reply", 16'(r), 16'(e));
    wt(BIT);
  endtask : rx
  task automatic tx(input logic [7:0] b, input logic brk);
    host_u.send(b, brk);
    rx(fr(b, brk));
  endtask : tx
  task automatic adr(input logic [7:0] op);
    tx(op, 1'b0);
    tx(a[15:8], 1'b0);
    tx(a[7:0], 1'b0);
  endtask : adr
  task automatic sec(input logic bad);
    wt(20);
    for (int i = 0; i < 8; i++) tx(mem[SEC_BASE + 16'(i)] ^ 8'(bad), 1'b0);
    rx(9'h000);
  endtask : sec
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    foreach (mem[i]) begin
      rnd = nx(rnd);
      mem[i] = rnd[7:0];
    end
    for (int i = 0; i < 8; i++) mem[SEC_BASE + 16'(i)] = ERASED_BYTE;
    mem[16'h9000] = 8'hA5;
    sp_i = rnd[31:16];
    wt(4);
    rst_n_i = 1'b1;
    sec(1'b0);
    chk("mode", 16'(monitor_mode_o), 16'h0001);
    chk("svec", swi_vector_o, VEC_SWI_MON);
    chk("bypass", 16'(security_bypass_o), 16'h0001);
    $display("entry done");
    for (int k = 0; k < 4; k++) begin
      rnd = nx(rnd);
      a = (k == 0) ? 16'hFFFF : rnd[15:0];
      d = rnd[23:16];
      adr(CMD_READ);
      rx({1'b1, mem[a]});
      wt(12 * BIT);
      tx(CMD_INDEXED_READ_CMD, 1'b0);
      rx({1'b1, mem[a + 16'h0001]});
      rx({1'b1, mem[a + 16'h0002]});
      wt(12 * BIT);
      tx(CMD_INDEXED_WRITE_CMD, 1'b0);
      tx(d, 1'b0);
      wt(12 * BIT);
      chk("indexed_write_cmd", 16'(mem[a + 16'h0003]), 16'(d));
      o = mem[a];
      adr(CMD_WRITE);
      tx(~d, 1'b0);
      tx(8'h00, 1'b1);
      wt(12 * BIT);
      chk("cancel", 16'(mem[a]), 16'(o));
    end
    $display("commands done");
    tx(CMD_STACK_POINTER_QUERY_CMD, 1'b0);
    a = sp_i + 16'h0001;
    rx({1'b1, a[15:8]});
    rx({1'b1, a[7:0]});
    wt(12 * BIT);
    tx(CMD_RUN, 1'b0);
    for (int i = 0; i < 14 * BIT && resume_o !== 1'b1; i++) wt(1);
    chk("resume", 16'(resume_o), 16'h0001);
    cpu_reset_i = 1'b1;
    wt(4);
    cpu_reset_i = 1'b0;
    sec(1'b1);
    chk("sticky", 16'(security_bypass_o), 16'h0001);
    irq_high_voltage_i = 1'b0;
    wt(20);
    chk("wdog", 16'(watchdog_disable_o), 16'h0000);
    chk("clksel", 16'(bus_clk_xtal_o), 16'h0000);
    clk_sel_bit_i = 1'b1;
    wt(4);
    chk("clksel", 16'(bus_clk_xtal_o), 16'h0001);
    rst_n_i = 1'b0;
    irq_high_voltage_i = 1'b1;
    wt(4);
    rst_n_i = 1'b1;
    sec(1'b1);
    chk("lock", 16'(nv_lock_o), 16'h0001);
    chk("bypass", 16'(security_bypass_o), 16'h0000);
    a = 16'h9000;
    adr(CMD_READ);
    rx({1'b1, UNDEF_BYTE});
    $display("security done");
    report_and_stop();
  end
endmodule : mswc_monitor_tb_top
